// *** core/pulse_sample_accumulator.sv ***
// Pulse and sample accumulator of a two-slot photometric front end.
// Assumes converter results arrive as one-cycle strobes tagged with their slot.
// Overview of operation
// - Pulses per internal sample come from an 8-bit count field per slot.
// - A 3-bit field per slot sets how many internal samples are combined.
// - Effective pulses per output equal pulse count times combined samples.
// - One output value is emitted per group of combined samples.
// - In chop mode inverted pulses whose math bit selects subtract are subtracted, all others added.
// - Reverse bias is applied only when the bias enable bit is one.
// - A 2-bit bias level per slot selects the bias, code 2 being moderate.
// - A 4-bit chop pattern per slot marks inverted pulses and repeats every four.
// - Math control fields pick add or subtract for each of four pulse positions.
//
// Chosen here: register access over Avalon-MM.
`timescale 1ns/1ps
module pulse_sample_accumulator (
	input  wire logic                       ref_clk_i,
	input  wire logic                       rst_n_i,
	input  wire logic [psa_pkg::ADDR_W-1:0] avs_address_i,
	input  wire logic                       avs_read_i,
	input  wire logic                       avs_write_i,
	input  wire logic [psa_pkg::DATA_W-1:0] avs_writedata_i,
	input  wire logic [3:0]                 avs_byteenable_i,
	output logic      [psa_pkg::DATA_W-1:0] avs_readdata_o,
	output logic                            avs_waitrequest_o,
	input  wire logic                       adc_valid_i,
	input  wire logic                       adc_slot_i,
	input  wire logic [psa_pkg::ADC_W-1:0]  adc_data_i,
	output logic                            out_valid_o,
	output logic                            out_slot_o,
	output logic      [psa_pkg::ACC_W-1:0]  out_data_o,
	output logic                            chop_invert_o,
	output logic                            bias_enable_o,
	output logic      [1:0]                 bias_level_a_o,
	output logic      [1:0]                 bias_level_b_o,
	output logic      [5:0]                 amp_power_down_o,
	output logic      [15:0]                sample_freq_o
);
	import psa_pkg::*;

	typedef enum logic [1:0] {
		BUS_IDLE = 2'b00,
		BUS_ACK  = 2'b01
	} bus_state_t;

	// Byte-lane merge of a 16-bit register
	function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] wd, input logic [3:0] be);
		merge16 = old;
		if (be[0]) merge16[7:0] = wd[7:0];
		if (be[1]) merge16[15:8] = wd[15:8];
	endfunction

	// Combine count code n means 2^n samples
	function automatic logic [7:0] combine_count(input logic [2:0] code);
		combine_count = 8'h01 << code;
	endfunction

	// Subtract when chop pattern marks the pulse and math field selects subtraction
	function automatic logic pulse_negate(input logic [3:0] pat, input logic [3:0] math, input logic [1:0] pos);
		pulse_negate = pat[pos] & math[pos];
	endfunction

	// Each 2-bit math field keeps the later pulse in its low bit, the earlier in its high bit
	function automatic logic [3:0] math_order(input logic [15:0] m, input int lo01, input int lo23);
		math_order[0] = m[lo01 + 1];
		math_order[1] = m[lo01];
		math_order[2] = m[lo23 + 1];
		math_order[3] = m[lo23];
	endfunction

	bus_state_t       bus_reg, bus_next;
	logic [31:0]      rdata_reg, rdata_next;
	logic [15:0]      freq_reg, freq_next, comb_reg, comb_next, chop_a_reg, chop_a_next;
	logic [15:0]      chop_b_reg, chop_b_next, pulse_a_reg, pulse_a_next, pulse_b_reg, pulse_b_next;
	logic [15:0]      pwdn_reg, pwdn_next, bias_reg, bias_next, math_reg, math_next;
	logic [ACC_W-1:0] acc_reg [2];
	logic [ACC_W-1:0] acc_next [2];
	logic [ACC_W-1:0] res_reg [2];
	logic [ACC_W-1:0] res_next [2];
	logic [7:0]       pcnt_reg [2];
	logic [7:0]       pcnt_next [2];
	logic [7:0]       scnt_reg [2];
	logic [7:0]       scnt_next [2];
	logic [1:0]       done_reg, done_next;
	logic             ov_reg, ov_next, os_reg, os_next;
	logic [ACC_W-1:0] od_reg, od_next;
	logic             inv_reg, inv_next;
	logic [7:0]       idx;
	logic             hit;

	assign idx = avs_address_i[9:2];
	// Writes land on the answer edge, while the master still holds the request
	assign hit = (bus_reg == BUS_ACK) && avs_write_i;

	always_comb begin
		bus_next = BUS_IDLE;
		rdata_next = rdata_reg;
		freq_next = freq_reg;
		comb_next = comb_reg;
		chop_a_next = chop_a_reg;
		chop_b_next = chop_b_reg;
		pulse_a_next = pulse_a_reg;
		pulse_b_next = pulse_b_reg;
		pwdn_next = pwdn_reg;
		bias_next = bias_reg;
		math_next = math_reg;
		if (bus_reg == BUS_IDLE && (avs_read_i || avs_write_i)) begin
			bus_next = BUS_ACK;
			case (idx)
				IDX_SAMPLE_FREQ:  rdata_next = {16'h0000, freq_reg};
				IDX_COMBINE_CTRL: rdata_next = {16'h0000, comb_reg};
				IDX_CHOP_A:       rdata_next = {16'h0000, chop_a_reg};
				IDX_CHOP_B:       rdata_next = {16'h0000, chop_b_reg};
				IDX_PULSE_A:      rdata_next = {16'h0000, pulse_a_reg};
				IDX_PULSE_B:      rdata_next = {16'h0000, pulse_b_reg};
				IDX_AMP_PWDN:     rdata_next = {16'h0000, pwdn_reg};
				IDX_BIAS_CTRL:    rdata_next = {16'h0000, bias_reg};
				IDX_MATH_CTRL:    rdata_next = {16'h0000, math_reg};
				IDX_STATUS:       rdata_next = {30'h0, done_reg};
				IDX_RESULT_A:     rdata_next = res_reg[0];
				IDX_RESULT_B:     rdata_next = res_reg[1];
				default:          rdata_next = 32'h00000000;
			endcase
		end
		if (hit) begin
			case (idx)
				IDX_SAMPLE_FREQ:  freq_next = merge16(freq_reg, avs_writedata_i, avs_byteenable_i);
				IDX_COMBINE_CTRL: comb_next = merge16(comb_reg, avs_writedata_i, avs_byteenable_i);
				IDX_CHOP_A:       chop_a_next = merge16(chop_a_reg, avs_writedata_i, avs_byteenable_i);
				IDX_CHOP_B:       chop_b_next = merge16(chop_b_reg, avs_writedata_i, avs_byteenable_i);
				IDX_PULSE_A:      pulse_a_next = merge16(pulse_a_reg, avs_writedata_i, avs_byteenable_i);
				IDX_PULSE_B:      pulse_b_next = merge16(pulse_b_reg, avs_writedata_i, avs_byteenable_i);
				IDX_AMP_PWDN:     pwdn_next = merge16(pwdn_reg, avs_writedata_i, avs_byteenable_i);
				IDX_BIAS_CTRL:    bias_next = merge16(bias_reg, avs_writedata_i, avs_byteenable_i);
				IDX_MATH_CTRL:    math_next = merge16(math_reg, avs_writedata_i, avs_byteenable_i);
				default:          ;
			endcase
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (!rst_n_i) begin
			bus_reg <= BUS_IDLE;
			rdata_reg <= 32'h00000000;
			freq_reg <= RST_SAMPLE_FREQ;
			comb_reg <= RST_COMBINE;
			chop_a_reg <= RST_CHOP;
			chop_b_reg <= RST_CHOP;
			pulse_a_reg <= RST_PULSE;
			pulse_b_reg <= RST_PULSE;
			pwdn_reg <= RST_AMP_PWDN;
			bias_reg <= RST_BIAS;
			math_reg <= RST_MATH;
		end else begin
			bus_reg <= bus_next;
			rdata_reg <= rdata_next;
			freq_reg <= freq_next;
			comb_reg <= comb_next;
			chop_a_reg <= chop_a_next;
			chop_b_reg <= chop_b_next;
			pulse_a_reg <= pulse_a_next;
			pulse_b_reg <= pulse_b_next;
			pwdn_reg <= pwdn_next;
			bias_reg <= bias_next;
			math_reg <= math_next;
		end
	end

	// Accumulation datapath, one lane per slot
	logic [7:0]       pulses_s;
	logic [7:0]       samples_s;
	logic [3:0]       pat_s, math_s;
	logic             neg_s, chop_s, avg_s;
	logic [ACC_W-1:0] term_s, sum_s;
	logic [2:0]       code_s;
	logic             s;

	always_comb begin
		s = adc_slot_i;
		pulses_s = s ? pulse_b_reg[PULSE_CNT_LSB +: 8] : pulse_a_reg[PULSE_CNT_LSB +: 8];
		code_s = s ? comb_reg[COMB_B_LSB +: 3] : comb_reg[COMB_A_LSB +: 3];
		samples_s = combine_count(code_s);
		avg_s = comb_reg[COMB_AVG_BIT];
		pat_s = s ? chop_b_reg[3:0] : chop_a_reg[3:0];
		chop_s = s ? chop_b_reg[CHOP_EN_BIT] : chop_a_reg[CHOP_EN_BIT];
		math_s = s ? math_order(math_reg, MATH_B_P01_LSB, MATH_B_P23_LSB)
		           : math_order(math_reg, MATH_A_P01_LSB, MATH_A_P23_LSB);
		neg_s = chop_s & pulse_negate(pat_s, math_s, pcnt_reg[s][1:0]);
		term_s = {{(ACC_W-ADC_W){1'b0}}, adc_data_i};
		// Chop relies on an even pulse count so offsets pair out
		sum_s = neg_s ? acc_reg[s] - term_s : acc_reg[s] + term_s;
		for (int k = 0; k < 2; k++) begin
			acc_next[k] = acc_reg[k];
			pcnt_next[k] = pcnt_reg[k];
			scnt_next[k] = scnt_reg[k];
			res_next[k] = res_reg[k];
		end
		done_next = done_reg;
		if (hit && idx == IDX_STATUS) done_next = done_reg & ~avs_writedata_i[1:0];
		ov_next = 1'b0;
		os_next = os_reg;
		od_next = od_reg;
		// Flag holds between pulses; it reports the last accepted one
		inv_next = inv_reg;
		if (adc_valid_i) begin
			acc_next[s] = sum_s;
			inv_next = neg_s;
			pcnt_next[s] = pcnt_reg[s] + 8'h01;
			// Effective pulses per output are pulses times samples
			if (pcnt_reg[s] + 8'h01 >= pulses_s) begin
				pcnt_next[s] = 8'h00;
				scnt_next[s] = scnt_reg[s] + 8'h01;
				if (scnt_reg[s] + 8'h01 >= samples_s) begin
					ov_next = 1'b1;
					os_next = s;
					od_next = avg_s ? (sum_s >> code_s) : sum_s;
					res_next[s] = od_next;
					done_next[s] = 1'b1; // Set wins over a same-cycle clear
					acc_next[s] = '0;
					scnt_next[s] = 8'h00;
				end
			end
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (!rst_n_i) begin
			for (int k = 0; k < 2; k++) begin
				acc_reg[k] <= '0;
				pcnt_reg[k] <= 8'h00;
				scnt_reg[k] <= 8'h00;
				res_reg[k] <= '0;
			end
			done_reg <= 2'b00;
			ov_reg <= 1'b0;
			os_reg <= 1'b0;
			od_reg <= '0;
			inv_reg <= 1'b0;
		end else begin
			for (int k = 0; k < 2; k++) begin
				acc_reg[k] <= acc_next[k];
				pcnt_reg[k] <= pcnt_next[k];
				scnt_reg[k] <= scnt_next[k];
				res_reg[k] <= res_next[k];
			end
			done_reg <= done_next;
			ov_reg <= ov_next;
			os_reg <= os_next;
			od_reg <= od_next;
			inv_reg <= inv_next;
		end
	end

	// Pin flops fed from next values, so pins move on the same edge as the registers
	logic             wait_reg, wait_next;
	logic             ben_reg, ben_next;
	logic [1:0]       lvl_a_reg, lvl_a_next;
	logic [1:0]       lvl_b_reg, lvl_b_next;
	logic [5:0]       apd_reg, apd_next;
	logic [15:0]      sfo_reg, sfo_next;

	always_comb begin
		wait_next = (bus_next == BUS_IDLE);
		ben_next = bias_next[BIAS_EN_BIT];
		lvl_a_next = 2'h0;
		lvl_b_next = 2'h0;
		// Levels forced to zero while bias is off, so no stray bias reaches the diode
		if (bias_next[BIAS_EN_BIT]) begin
			lvl_a_next = bias_next[BIAS_A_LSB +: 2];
			lvl_b_next = bias_next[BIAS_B_LSB +: 2];
		end
		apd_next = pwdn_next[PWDN_LSB +: 6];
		sfo_next = freq_next;
	end

	always_ff @(posedge ref_clk_i) begin
		if (!rst_n_i) begin
			wait_reg <= 1'b1;
			ben_reg <= RST_BIAS[BIAS_EN_BIT];
			lvl_a_reg <= 2'h0;
			lvl_b_reg <= 2'h0;
			apd_reg <= RST_AMP_PWDN[PWDN_LSB +: 6];
			sfo_reg <= RST_SAMPLE_FREQ;
		end else begin
			wait_reg <= wait_next;
			ben_reg <= ben_next;
			lvl_a_reg <= lvl_a_next;
			lvl_b_reg <= lvl_b_next;
			apd_reg <= apd_next;
			sfo_reg <= sfo_next;
		end
	end

	assign avs_readdata_o = rdata_reg;
	assign avs_waitrequest_o = wait_reg;
	assign out_valid_o = ov_reg;
	assign out_slot_o = os_reg;
	assign out_data_o = od_reg;
	assign chop_invert_o = inv_reg;
	assign bias_enable_o = ben_reg;
	assign bias_level_a_o = lvl_a_reg;
	assign bias_level_b_o = lvl_b_reg;
	assign amp_power_down_o = apd_reg;
	assign sample_freq_o = sfo_reg;
endmodule

// *** pkg/psa_pkg.sv ***
// Constants for the pulse sample accumulator: register map, field layout, resets.
// Assumes a 32-bit Avalon-MM slave with word addressing from byte offsets.
package psa_pkg;
	localparam int ADDR_W = 10;
	localparam int DATA_W = 32;
	localparam int ACC_W  = 32;
	localparam int ADC_W  = 14;
	// Register byte addresses are four times the printed index
	localparam logic [7:0] IDX_SAMPLE_FREQ   = 8'h12;
	localparam logic [7:0] IDX_COMBINE_CTRL  = 8'h15;
	localparam logic [7:0] IDX_CHOP_A        = 8'h17;
	localparam logic [7:0] IDX_CHOP_B        = 8'h1D;
	localparam logic [7:0] IDX_PULSE_A       = 8'h31;
	localparam logic [7:0] IDX_PULSE_B       = 8'h36;
	localparam logic [7:0] IDX_AMP_PWDN      = 8'h3C;
	localparam logic [7:0] IDX_BIAS_CTRL     = 8'h54;
	localparam logic [7:0] IDX_MATH_CTRL     = 8'h58;
	localparam logic [7:0] IDX_STATUS        = 8'h70;
	localparam logic [7:0] IDX_RESULT_A      = 8'h71;
	localparam logic [7:0] IDX_RESULT_B      = 8'h72;
	// Field positions
	localparam int PULSE_CNT_LSB   = 8;
	localparam int COMB_A_LSB      = 4;
	localparam int COMB_B_LSB      = 8;
	localparam int COMB_AVG_BIT    = 0;
	localparam int CHOP_EN_BIT     = 15;
	localparam int BIAS_EN_BIT     = 7;
	localparam int BIAS_A_LSB      = 8;
	localparam int BIAS_B_LSB      = 10;
	localparam int PWDN_LSB        = 3;
	// Math control pulse positions, slot A then slot B
	localparam int MATH_A_P01_LSB  = 1;
	localparam int MATH_A_P23_LSB  = 8;
	localparam int MATH_B_P01_LSB  = 5;
	localparam int MATH_B_P23_LSB  = 10;
	// Reset values
	localparam logic [15:0] RST_SAMPLE_FREQ  = 16'h0028;
	localparam logic [15:0] RST_COMBINE      = 16'h0000;
	localparam logic [15:0] RST_CHOP         = 16'h0000;
	localparam logic [15:0] RST_PULSE        = 16'h0100;
	localparam logic [15:0] RST_AMP_PWDN     = 16'h0000;
	localparam logic [15:0] RST_BIAS         = 16'h0000;
	localparam logic [15:0] RST_MATH         = 16'h0000;
	localparam logic [1:0]  BIAS_MODERATE    = 2'h2;
endpackage

// *** sim/psa_asserts.sv ***
// Checker for the accumulator: bus answer timing, output strobe, bias gating.
// Assumes binding to the top module; sees only its ports.
`timescale 1ns/1ps
module psa_asserts (
	input wire logic                      ref_clk_i,
	input wire logic                      rst_n_i,
	input wire logic                      avs_read_i,
	input wire logic                      avs_write_i,
	input wire logic                      avs_waitrequest_o,
	input wire logic                      adc_valid_i,
	input wire logic                      adc_slot_i,
	input wire logic                      out_valid_o,
	input wire logic                      out_slot_o,
	input wire logic [psa_pkg::ACC_W-1:0] out_data_o,
	input wire logic                      chop_invert_o,
	input wire logic                      bias_enable_o,
	input wire logic [1:0]                bias_level_a_o,
	input wire logic [1:0]                bias_level_b_o
);
	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (!rst_n_i);
	sequence s_req;
		(avs_read_i || avs_write_i) && avs_waitrequest_o;
	endsequence
	sequence s_answer;
		!avs_waitrequest_o ##1 avs_waitrequest_o;
	endsequence
	a_wait_answer: assert property (s_req |=> s_answer)
		else $error("bus answer not one cycle after request");
	a_wait_single: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
		else $error("waitrequest low longer than one cycle");
	a_wait_idle: assert property (!(avs_read_i || avs_write_i) && avs_waitrequest_o |=> avs_waitrequest_o)
		else $error("answer without request");
	a_out_cause: assert property (out_valid_o |-> $past(adc_valid_i))
		else $error("output without a pulse result before it");
	a_out_slot: assert property (out_valid_o |-> out_slot_o == $past(adc_slot_i))
		else $error("output slot differs from last pulse slot");
	a_data_hold: assert property ($changed(out_data_o) || $changed(out_slot_o) |-> out_valid_o)
		else $error("output data changed without strobe");
	a_chop_cause: assert property ($changed(chop_invert_o) |-> $past(adc_valid_i))
		else $error("chop flag moved without a pulse");
	a_bias_gate: assert property (!bias_enable_o |-> bias_level_a_o == 2'h0 && bias_level_b_o == 2'h0)
		else $error("bias level driven while bias disabled");
endmodule
bind pulse_sample_accumulator psa_asserts u_psa_asserts (
	.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
	.avs_waitrequest_o(avs_waitrequest_o), .adc_valid_i(adc_valid_i), .adc_slot_i(adc_slot_i),
	.out_valid_o(out_valid_o), .out_slot_o(out_slot_o), .out_data_o(out_data_o),
	.chop_invert_o(chop_invert_o), .bias_enable_o(bias_enable_o),
	.bias_level_a_o(bias_level_a_o), .bias_level_b_o(bias_level_b_o));

// *** sim/pulse_sample_accumulator_bench.sv ***
// Bench for the accumulator: bus tasks, pulse driver, expected sums.
// Assumes the design package; 200 MHz clock.
`timescale 1ns/1ps
module pulse_sample_accumulator_bench;
	import psa_pkg::*;
	logic              ref_clk_i = 1'b0;
	logic              rst_n_i   = 1'b0;
	logic [ADDR_W-1:0] adr       = '0;
	logic              rd = 1'b0, wr = 1'b0, av = 1'b0, as = 1'b0;
	logic [DATA_W-1:0] wd = '0, rdata, q;
	logic [ADC_W-1:0]  ad = '0;
	logic              ov, os, ci, be, wt;
	logic [ACC_W-1:0]  od;
	logic [1:0]        bla, blb;
	logic [5:0]        pd;
	logic [15:0]       sf;
	int                err_count = 0;
	int                checks    = 0;
	always #2.5 ref_clk_i = ~ref_clk_i;
	// Byte enables tied: all writable registers are 16 bits in the low lanes
	pulse_sample_accumulator u_pulse_sample_accumulator (
		.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .avs_address_i(adr), .avs_read_i(rd),
		.avs_write_i(wr), .avs_writedata_i(wd), .avs_byteenable_i(4'hF), .avs_readdata_o(rdata),
		.avs_waitrequest_o(wt), .adc_valid_i(av), .adc_slot_i(as), .adc_data_i(ad),
		.out_valid_o(ov), .out_slot_o(os), .out_data_o(od), .chop_invert_o(ci),
		.bias_enable_o(be), .bias_level_a_o(bla), .bias_level_b_o(blb),
		.amp_power_down_o(pd), .sample_freq_o(sf));
	task stop_test;
		$display("errors %0d checks %0d", err_count, checks);
		if (err_count == 0 && checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task chk(input string n, input logic [31:0] e, input logic [31:0] g);
		checks++;
		if (g !== e) begin
			err_count++;
			$display("unexpected %s exp %h got %h", n, e, g);
		end
	endtask
	task bus(input logic w, input logic [7:0] idx, input logic [15:0] d);
		int n;
		@(posedge ref_clk_i);
		adr <= {idx, 2'b00};
		rd <= !w;
		wr <= w;
		wd <= {16'h0000, d};
		n = 0;
		do begin
			@(posedge ref_clk_i);
			n++;
		end while (wt !== 1'b0 && n < 50);
		if (wt !== 1'b0) begin
			err_count++;
			stop_test;
		end
		q = rdata;
		rd <= 1'b0;
		wr <= 1'b0;
	endtask
	task rd_chk(input string n, input logic [7:0] idx, input logic [31:0] e);
		bus(1'b0, idx, 16'h0000);
		chk(n, e, q);
	endtask
	task ochk(input logic v, input logic s, input logic [31:0] e);
		@(posedge ref_clk_i);
		chk("out_valid", 32'(v), 32'(ov));
		if (v) begin
			chk("out_slot", 32'(s), 32'(os));
			chk("out_data", e, od);
		end
	endtask
	// Pulses spaced three cycles apart; a strobe is never reasserted in its own step
	task send(input logic s, input int n, input logic [13:0] d, input logic [13:0] st, input logic [31:0] e);
		for (int i = 0; i < n; i++) begin
			@(posedge ref_clk_i);
			av <= 1'b1;
			as <= s;
			ad <= d - 14'(i) * st;
			@(posedge ref_clk_i);
			av <= 1'b0;
			ochk(i == n - 1, s, e);
		end
	endtask
	initial begin
		repeat (100000) @(posedge ref_clk_i);
		err_count++;
		stop_test;
	end
	initial begin
		repeat (12) @(posedge ref_clk_i);
		rst_n_i <= 1'b1;
		rd_chk("sample_frequency", IDX_SAMPLE_FREQ, {16'h0000, RST_SAMPLE_FREQ});
		rd_chk("slot_a_pulse_control", IDX_PULSE_A, {16'h0000, RST_PULSE});
		rd_chk("sample_combine_control", IDX_COMBINE_CTRL, {16'h0000, RST_COMBINE});
		send(1'b0, 1, 14'h0123, 14'h0000, 32'h00000123);
		bus(1'b1, IDX_PULSE_A, 16'h0200);
		bus(1'b1, IDX_COMBINE_CTRL, 16'h0210);
		send(1'b0, 4, 14'h0100, 14'h0010, 32'h000003A0);
		send(1'b0, 4, 14'h0010, 14'h0001, 32'h0000003A);
		send(1'b1, 4, 14'h3FFF, 14'h0000, 32'h0000FFFC);
		rd_chk("status", IDX_STATUS, 32'h00000003);
		bus(1'b1, IDX_STATUS, 16'h0001);
		rd_chk("status_clear", IDX_STATUS, 32'h00000002);
		rd_chk("result_b", IDX_RESULT_B, 32'h0000FFFC);
		bus(1'b1, IDX_PULSE_A, 16'h0400);
		bus(1'b1, IDX_COMBINE_CTRL, 16'h0000);
		// Offsets live outside this block; zeroed anyway as chop needs
		bus(1'b1, 8'h18, 16'h0000);
		bus(1'b1, 8'h1E, 16'h0000);
		bus(1'b1, IDX_CHOP_A, 16'h800A);
		bus(1'b1, IDX_MATH_CTRL, 16'h0102);
		rd_chk("chop_a", IDX_CHOP_A, 32'h0000800A);
		send(1'b0, 4, 14'h0200, 14'h0040, 32'h00000080);
		chk("chop_invert", 32'h1, 32'(ci));
		bus(1'b1, IDX_BIAS_CTRL, 16'h0680);
		@(posedge ref_clk_i);
		chk("bias_enable", 32'h1, 32'(be));
		chk("bias_level_a", 32'(BIAS_MODERATE), 32'(bla));
		chk("bias_level_b", 32'h1, 32'(blb));
		bus(1'b1, IDX_BIAS_CTRL, 16'h0600);
		@(posedge ref_clk_i);
		chk("bias_off", 32'h0, {27'h0, be, bla, blb});
		bus(1'b1, IDX_AMP_PWDN, 16'h0090);
		bus(1'b1, IDX_SAMPLE_FREQ, 16'h00A0);
		@(posedge ref_clk_i);
		chk("amp_power_down", 32'h12, 32'(pd));
		chk("sample_freq", 32'hA0, 32'(sf));
		rd_chk("amplifier_power_down", IDX_AMP_PWDN, 32'h00000090);
		rd_chk("unmapped", 8'h40, 32'h00000000);
		bus(1'b1, IDX_CHOP_A, 16'h0000);
		bus(1'b1, IDX_PULSE_A, 16'h0100);
		bus(1'b1, IDX_COMBINE_CTRL, 16'h0011);
		send(1'b0, 2, 14'h0100, 14'h0080, 32'h000000C0);
		chk("chop_invert_off", 32'h0, 32'(ci));
		stop_test;
	end
endmodule
